/* inc/tcc_pkg.sv */
/*
  Constants for the timer channel 2 compare and mode control block:
  register offsets, field positions, mode codes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tcc_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] ADDR_CTL  = 8'h1c;
  localparam logic [7:0] ADDR_EN   = 8'h20;
  localparam logic [7:0] ADDR_CV   = 8'h40;
  localparam logic [7:0] ADDR_ADD  = 8'h44;
  localparam logic [7:0] ADDR_CFG  = 8'h48;
  localparam logic [7:0] ADDR_STAT = 8'h4c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int B_MS_HI   = 30;
  localparam int B_ADD_SEN = 28;
  localparam int B_CLR_EN  = 7;
  localparam int B_MODE    = 4;
  localparam int B_SEN     = 3;
  localparam int B_MS_LO   = 0;
  localparam int B_CH2_ENABLE   = 8;
  localparam int B_CH2_POLARITY    = 9;
  localparam int B_MULTI_CH2_ENABLE  = 10;
  localparam int B_MULTI_CH2_POLARITY   = 11;
  localparam int B_PROTECTION_LEVEL    = 0;
  localparam int B_MSEL    = 2;
  localparam int B_CPWM    = 4;
  localparam int B_SPM     = 5;
  localparam int B_ST_PREP = 0;
  localparam int B_ST_ISEL = 1;
  localparam int B_ST_DOWN = 2;

  // ****************************************
  // Mode codes
  // ****************************************
  localparam logic [2:0] OC_TIMING = 3'h0;
  localparam logic [2:0] OC_SET    = 3'h1;
  localparam logic [2:0] OC_CLR    = 3'h2;
  localparam logic [2:0] OC_TOG    = 3'h3;
  localparam logic [2:0] OC_FLO    = 3'h4;
  localparam logic [2:0] OC_FHI    = 3'h5;
  localparam logic [2:0] OC_PWM0   = 3'h6;
  localparam logic [2:0] OC_PWM1   = 3'h7;
  localparam logic [2:0] IO_OUT    = 3'h0;
  localparam logic [2:0] IO_OWN    = 3'h1;
  localparam logic [2:0] IO_CH3    = 3'h2;
  localparam logic [2:0] IO_ITRG   = 3'h3;
  localparam logic [2:0] IO_MULTI  = 3'h4;
  localparam logic [1:0] MSEL_NONE = 2'h0;
  localparam logic [1:0] MSEL_BOTH = 2'h3;
  localparam logic [1:0] PROTECTION_LEVEL_MAX  = 2'h3;
  localparam logic [1:0] HTRANS_NS = 2'h2;
endpackage : tcc_pkg

/* inc/tcc_cmp_if.sv */
/*
  Carrier between the control top and the compare generator.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface tcc_cmp_if #(parameter int CNT_W = 16);
  logic [2:0]       mode;
  logic             clear_en;
  logic             composite;
  logic             count_down;
  logic             tick;
  logic             ext_trig;
  logic [CNT_W-1:0] counter;
  logic [CNT_W-1:0] cv;
  logic [CNT_W-1:0] add_cv;
  logic             prep;
  modport ctl (output mode, clear_en, composite, count_down, tick,
               ext_trig, counter, cv, add_cv, input prep);
  modport gen (input mode, clear_en, composite, count_down, tick,
               ext_trig, counter, cv, add_cv, output prep);
endinterface : tcc_cmp_if
`default_nettype wire

/* src/tcc_ch2_oc.sv */
/*
  Channel 2 output-prepare generator.
  Assumes counter, compare values and tick share the block clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tcc_ch2_oc (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  tcc_cmp_if.gen    cif
);
  import tcc_pkg::*;

  typedef struct packed {
    logic prep;
  } tcc_oc_st_t;

  tcc_oc_st_t st_q;
  tcc_oc_st_t st_d;
  logic       lt;
  logic       gt;
  logic       eq;
  logic       act;

  // Composite window: active from main compare up to the extra compare
  function automatic logic in_win(input logic [31:0] c,
                                  input logic [31:0] lo,
                                  input logic [31:0] hi);
    in_win = (c >= lo) && (c < hi);
  endfunction : in_win

  assign lt = cif.counter < cif.cv;
  assign gt = cif.counter > cif.cv;
  assign eq = cif.counter == cif.cv;
  assign cif.prep = st_q.prep;

  always_comb begin
    st_d = st_q;
    act  = 1'b0;
    if (cif.composite) begin
      act = in_win(32'(cif.counter), 32'(cif.cv), 32'(cif.add_cv));
    end else if (cif.count_down) begin
      act = ~gt;
    end else begin
      act = lt;
    end
    // Match and PWM levels only move with the tick; modes 100/101 and the clear act at once
    case (cif.mode)
      OC_TIMING: st_d.prep = st_q.prep;
      OC_SET: if (cif.tick && eq) st_d.prep = 1'b1;
      OC_CLR: if (cif.tick && eq) st_d.prep = 1'b0;
      OC_TOG: if (cif.tick && eq) st_d.prep = ~st_q.prep;
      OC_FLO: st_d.prep = 1'b0;
      OC_FHI: st_d.prep = 1'b1;
      OC_PWM0: if (cif.tick) st_d.prep = act;
      OC_PWM1: if (cif.tick) st_d.prep = ~act;
      default: st_d.prep = st_q.prep;
    endcase
    if (cif.clear_en && cif.ext_trig) begin
      st_d.prep = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end
endmodule : tcc_ch2_oc
`default_nettype wire

/* src/tcc_ch2_ctrl.sv */
/*
  Timer channel 2 compare mode control: register file on AHB-Lite,
  shadowed compare values, write locks, input selection, outputs.
  Assumes counter, direction, tick, update event and filtered inputs
  come from timer logic on ref_clk; the external trigger is a pin.
*/
// Behaviour
// - Clear enable plus high external trigger forces output-prepare low.
// - Output-prepare is active high; primary output inverts by its polarity.
// - Multi-mode select 11 drives multi output too, own polarity each.
// - Timing mode holds output-prepare unchanged.
// - On match: mode 001 sets, 010 clears, 011 toggles.
// - Mode 100 forces low, mode 101 forces high.
// - PWM0: up active below compare; down inactive above, else active.
// - PWM1: up inactive below compare; down active above, else inactive.
// - Composite PWM in output mode uses main and extra compare values.
// - PWM level changes only on mode entry or comparison change.
// - Protection 11 with output mode locks compare mode and shadow bit.
// - Shadow on: writes wait for update event; off: take effect now.
// - I/O mode field writable only while the channel is disabled.
// - Mode 00 output, 01 own input, 10 channel 3 input.
// - Mode 11 picks internal trigger, valid only if one is selected.
// - Mode 100 picks multi channel input; 101 to 111 reserved.
// - Mode field top bit sits at bit 30 of the control register.
`timescale 1ns/100ps
`default_nettype none
module tcc_ch2_ctrl #(
  parameter int CNT_W = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic [31:0]           hrdata,
  output logic                  hresp,
  input  wire logic [CNT_W-1:0] counter_value,
  input  wire logic             count_down,
  input  wire logic             cnt_tick,
  input  wire logic             update_event,
  input  wire logic             ext_trigger_pin,
  input  wire logic             ch2_own_filtered_in,
  input  wire logic             ch3_cross_filtered_in,
  input  wire logic             multi_ch2_filtered_in,
  input  wire logic             internal_trigger_sel,
  input  wire logic             trigger_is_internal,
  output logic                  ch2_primary_out,
  output logic                  multi_ch2_out,
  output logic                  ch2_input_select
);
  import tcc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic             ext_s1;
    logic             ext_s2;
    logic             dph_wr;
    logic [7:0]       dph_addr;
    logic             hready;
    logic             hresp;
    logic [31:0]      rdata;
    logic             clr_en;
    logic [2:0]       oc_mode;
    logic             sen;
    logic             add_sen;
    logic [2:0]       io_mode;
    logic             ch2_en;
    logic             ch2_pol;
    logic             mch2_en;
    logic             mch2_pol;
    logic [1:0]       protection_level;
    logic [1:0]       msel;
    logic             cpwm;
    logic             single_pulse_mode;
    logic [CNT_W-1:0] cv_sh;
    logic [CNT_W-1:0] cv;
    logic [CNT_W-1:0] add_sh;
    logic [CNT_W-1:0] add_cv;
    logic             out_p;
    logic             out_m;
    logic             isel;
  } tcc_st_t;

  localparam tcc_st_t ST_RST = '{hready: 1'b1, default: '0};

  tcc_st_t   st_q;
  tcc_st_t   st_d;
  logic      rst_s1_q;
  logic      rst_n;
  logic      prep;
  logic      lock;
  logic      ms_ok;
  logic      take;
  logic [31:0] wd;
  tcc_cmp_if #(.CNT_W(CNT_W)) cif ();

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic is_output(input logic [2:0] m);
    is_output = (m == IO_OUT);
  endfunction : is_output

  function automatic logic pin_level(input logic en,
                                     input logic p,
                                     input logic pol);
    pin_level = en && (p ^ pol);
  endfunction : pin_level

  // Mode field may change only while every enable in use is clear
  function automatic logic ch_idle(input tcc_st_t s);
    case (s.msel)
      MSEL_NONE: ch_idle = ~s.ch2_en;
      default:   ch_idle = ~s.ch2_en && ~s.mch2_en;
    endcase
  endfunction : ch_idle

  // Reserved and unmapped bits read as zero
  function automatic logic [31:0] rd_reg(input tcc_st_t s,
                                         input logic [7:0] a,
                                         input logic p);
    rd_reg = '0;
    case (a)
      ADDR_CTL: begin
        rd_reg[B_MS_HI]          = s.io_mode[2];
        rd_reg[B_ADD_SEN]        = s.add_sen;
        rd_reg[B_CLR_EN]         = s.clr_en;
        rd_reg[B_MODE +: 3]      = s.oc_mode;
        rd_reg[B_SEN]            = s.sen;
        rd_reg[B_MS_LO +: 2]     = s.io_mode[1:0];
      end
      ADDR_EN: begin
        rd_reg[B_CH2_ENABLE]  = s.ch2_en;
        rd_reg[B_CH2_POLARITY]   = s.ch2_pol;
        rd_reg[B_MULTI_CH2_ENABLE] = s.mch2_en;
        rd_reg[B_MULTI_CH2_POLARITY]  = s.mch2_pol;
      end
      ADDR_CV:  rd_reg[CNT_W-1:0] = s.cv_sh;
      ADDR_ADD: rd_reg[CNT_W-1:0] = s.add_sh;
      ADDR_CFG: begin
        rd_reg[B_PROTECTION_LEVEL +: 2] = s.protection_level;
        rd_reg[B_MSEL +: 2] = s.msel;
        rd_reg[B_CPWM]      = s.cpwm;
        rd_reg[B_SPM]       = s.single_pulse_mode;
      end
      ADDR_STAT: begin
        rd_reg[B_ST_PREP] = p;
        rd_reg[B_ST_ISEL] = s.isel;
        rd_reg[B_ST_DOWN] = count_down;
      end
      default: rd_reg = '0;
    endcase
  endfunction : rd_reg

  // ****************************************
  // Reset release
  // ****************************************
  // Release through two flops so no state leaves reset on a late edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ****************************************
  // Compare generator
  // ****************************************
  assign cif.mode       = st_q.oc_mode;
  assign cif.clear_en   = st_q.clr_en;
  // Composite only in output mode; an input channel has no compare
  assign cif.composite  = st_q.cpwm && is_output(st_q.io_mode);
  assign cif.count_down = count_down;
  assign cif.tick       = cnt_tick;
  assign cif.ext_trig   = st_q.ext_s2;
  assign cif.counter    = counter_value;
  assign cif.cv         = st_q.cv;
  assign cif.add_cv     = st_q.add_cv;
  assign prep           = cif.prep;

  tcc_ch2_oc u_oc (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .cif     (cif)
  );

  // ****************************************
  // Next state
  // ****************************************
  // Lock spares the clear enable; only mode and shadow bit are held
  assign lock = (st_q.protection_level == PROTECTION_LEVEL_MAX) && is_output(st_q.io_mode);
  assign take = hsel && hready && (htrans == HTRANS_NS);
  assign wd   = hwdata;

  always_comb begin
    st_d = st_q;
    // Trigger pin is asynchronous; only the second stage is read
    st_d.ext_s1 = ext_trigger_pin;
    st_d.ext_s2 = st_q.ext_s1;
    ms_ok = ch_idle(st_q);
    // Update event loads shadows before any same-cycle write lands
    if (update_event && st_q.sen) begin
      st_d.cv = st_q.cv_sh;
    end
    if (update_event && st_q.add_sen) begin
      st_d.add_cv = st_q.add_sh;
    end
    if (st_q.dph_wr) begin
      case (st_q.dph_addr)
        ADDR_CTL: begin
          st_d.clr_en  = wd[B_CLR_EN];
          st_d.add_sen = wd[B_ADD_SEN];
          if (!lock) begin
            st_d.oc_mode = wd[B_MODE +: 3];
            st_d.sen     = wd[B_SEN];
          end
          if (ms_ok) begin
            st_d.io_mode = {wd[B_MS_HI], wd[B_MS_LO +: 2]};
          end
        end
        ADDR_EN: begin
          st_d.ch2_en   = wd[B_CH2_ENABLE];
          st_d.ch2_pol  = wd[B_CH2_POLARITY];
          st_d.mch2_en  = wd[B_MULTI_CH2_ENABLE];
          st_d.mch2_pol = wd[B_MULTI_CH2_POLARITY];
        end
        ADDR_CV: begin
          st_d.cv_sh = wd[CNT_W-1:0];
          if (!st_q.sen) st_d.cv = wd[CNT_W-1:0];
        end
        ADDR_ADD: begin
          st_d.add_sh = wd[CNT_W-1:0];
          if (!st_q.add_sen) st_d.add_cv = wd[CNT_W-1:0];
        end
        ADDR_CFG: begin
          st_d.protection_level = wd[B_PROTECTION_LEVEL +: 2];
          st_d.msel = wd[B_MSEL +: 2];
          st_d.cpwm = wd[B_CPWM];
          st_d.single_pulse_mode  = wd[B_SPM];
        end
        default: st_d.cpwm = st_q.cpwm;
      endcase
    end
    // Bus: zero wait states, read data registered at the address edge
    st_d.hready   = 1'b1;
    // Only whole words are served, so every answer is OKAY
    st_d.hresp    = 1'b0;
    st_d.dph_wr   = take && hwrite;
    st_d.dph_addr = haddr[7:0];
    if (take && !hwrite) begin
      st_d.rdata = rd_reg(st_q, haddr[7:0], prep);
    end
    // Outputs: active-high prepare through each polarity
    st_d.out_p = is_output(st_q.io_mode)
                 && pin_level(st_q.ch2_en, prep, st_q.ch2_pol);
    st_d.out_m = is_output(st_q.io_mode) && (st_q.msel == MSEL_BOTH)
                 && pin_level(st_q.mch2_en, prep, st_q.mch2_pol);
    case (st_q.io_mode)
      IO_OWN:   st_d.isel = ch2_own_filtered_in;
      IO_CH3:   st_d.isel = ch3_cross_filtered_in;
      IO_ITRG:  st_d.isel = trigger_is_internal
                            && internal_trigger_sel;
      IO_MULTI: st_d.isel = multi_ch2_filtered_in;
      default:  st_d.isel = 1'b0;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  // Frozen by clk_en, bus included, so keep it high during traffic
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_RST;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign hreadyout        = st_q.hready;
  assign hrdata           = st_q.rdata;
  assign hresp            = st_q.hresp;
  assign ch2_primary_out  = st_q.out_p;
  assign multi_ch2_out    = st_q.out_m;
  assign ch2_input_select = st_q.isel;

  // Unused bus qualifiers: only whole-word single transfers are served
  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[31:8]};
endmodule : tcc_ch2_ctrl
`default_nettype wire

/* dv/tcc_ch2_ctrl_assertions.sv */
/*
  Port checker for tcc_ch2_ctrl, bound into every instance.
  Assumes the top ports keep their declared names and widths.
*/
`timescale 1ns/100ps
`default_nettype none
module tcc_ch2_ctrl_assertions (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        clk_en,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        count_down,
  input wire logic        ch2_primary_out,
  input wire logic        multi_ch2_out,
  input wire logic        ch2_input_select
);
  import tcc_pkg::*;
  // ****************
  // Helpers
  // ****************
  logic rd_take;
  logic mapped;
  assign rd_take = hsel && hready && htrans == HTRANS_NS && !hwrite
                   && clk_en;
  assign mapped = haddr[7:0] inside {ADDR_CTL, ADDR_EN, ADDR_CV,
                                     ADDR_ADD, ADDR_CFG, ADDR_STAT};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_rd_at(logic [7:0] a);
    rd_take && haddr[7:0] == a;
  endsequence
  sequence s_rd_odd;
    rd_take && !mapped;
  endsequence
  // ****************
  // Properties
  // ****************
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  a_ready_always: assert property (hreadyout == 1'b1)
    else $error("hreadyout low");
  a_unmapped_zero: assert property (s_rd_odd |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_status_down: assert property (s_rd_at(ADDR_STAT) |=>
    hrdata[B_ST_DOWN] == $past(count_down) && hrdata[31:3] == 29'h0)
    else $error("status read wrong");
  a_ctl_reserved: assert property (s_rd_at(ADDR_CTL) |=>
    hrdata[31] == 1'b0 && hrdata[29] == 1'b0 && hrdata[2] == 1'b0
    && hrdata[27:8] == 20'h0)
    else $error("control reserved bits set");
  a_rdata_holds: assert property (!rd_take |=> $stable(hrdata))
    else $error("hrdata moved without read");
  a_freeze_outputs: assert property (!clk_en |=> $stable(hrdata)
    && $stable(ch2_primary_out) && $stable(multi_ch2_out)
    && $stable(ch2_input_select))
    else $error("state moved while disabled");
  a_out_excl_input: assert property (
    (ch2_primary_out || multi_ch2_out) |-> !ch2_input_select)
    else $error("output and input select both active");
  c_odd_read: cover property (s_rd_odd);
endmodule : tcc_ch2_ctrl_assertions
bind tcc_ch2_ctrl tcc_ch2_ctrl_assertions i_chk (
  .ref_clk, .resetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hrdata, .hresp, .count_down, .ch2_primary_out,
  .multi_ch2_out, .ch2_input_select);
`default_nettype wire

/* dv/tb.sv */
/*
  Self-checking bench for tcc_ch2_ctrl.
  Assumes the package and the bound checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tcc_pkg::*;
  // ****************
  // Signals
  // ****************
  logic        ref_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        clk_en  = 1'b1;
  logic [31:0] haddr   = '0;
  logic [1:0]  htrans  = '0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = '0;
  logic [15:0] cnt     = '0;
  logic        down    = 1'b0;
  logic        tick    = 1'b0;
  logic        upd     = 1'b0;
  logic        trg     = 1'b0;
  logic        own     = 1'b1;
  logic        ch3     = 1'b0;
  logic        mul     = 1'b0;
  logic        itrg    = 1'b1;
  logic        tint    = 1'b1;
  logic        hreadyout, hresp, pout, mout, isel;
  logic [31:0] hrdata, q;
  int          num_errors  = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  // Mode, count, then direction times two plus level; compare value 10
  logic [15:0] rows [18] = '{16'h5001, 16'h0101, 16'h4000, 16'h0100,
    16'h1101, 16'h3100, 16'h3101, 16'h3051, 16'h2100, 16'h6051,
    16'h6100, 16'h6202, 16'h6053, 16'h6103, 16'h7050, 16'h7201,
    16'h7203, 16'h7102};

  tcc_ch2_ctrl i_tcc_ch2_ctrl (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .counter_value(cnt),
    .count_down(down), .cnt_tick(tick), .update_event(upd),
    .ext_trigger_pin(trg), .ch2_own_filtered_in(own),
    .ch3_cross_filtered_in(ch3), .multi_ch2_filtered_in(mul),
    .internal_trigger_sel(itrg), .trigger_is_internal(tint),
    .ch2_primary_out(pout), .multi_ch2_out(mout),
    .ch2_input_select(isel));

  always #2 ref_clk = ~ref_clk;
  // ****************
  // Tasks
  // ****************
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask : chk

  // Waits on hready rather than a fixed count; the timeout ends a hang
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge ref_clk);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NS;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic step(input logic [15:0] c, input logic dn);
    @(posedge ref_clk);
    cnt  <= c;
    down <= dn;
    tick <= 1'b1;
    @(posedge ref_clk);
    tick <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : step

  task automatic stat(input logic e);
    xfer(1'b0, ADDR_STAT, 0);
    chk("prepare", 32'(e), 32'(q[B_ST_PREP]));
  endtask : stat

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      finish_test();
    end
  end
  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    xfer(1'b0, ADDR_CTL, 0);
    chk("ctl reset", 0, q);
    xfer(1'b1, ADDR_CV, 32'h10);
    xfer(1'b1, ADDR_CFG, 32'h2c);
    xfer(1'b1, ADDR_EN, 32'hd00);
    foreach (rows[i]) begin
      xfer(1'b1, ADDR_CTL, {25'h0, rows[i][14:12], 4'h0});
      step({8'h0, rows[i][11:4]}, rows[i][1]);
      stat(rows[i][0]);
      chk("out", 32'(rows[i][0]), 32'(pout));
      chk("multi", 32'(!rows[i][0]), 32'(mout));
    end
    xfer(1'b1, ADDR_CTL, 32'h68);
    xfer(1'b1, ADDR_CV, 32'h30);
    step(16'h20, 1'b0);
    stat(1'b0);
    @(posedge ref_clk);
    upd <= 1'b1;
    @(posedge ref_clk);
    upd <= 1'b0;
    step(16'h20, 1'b0);
    stat(1'b1);
    xfer(1'b1, ADDR_ADD, 32'h50);
    xfer(1'b1, ADDR_CFG, 32'h3c);
    step(16'h40, 1'b1);
    stat(1'b1);
    step(16'h20, 1'b0);
    stat(1'b0);
    xfer(1'b1, ADDR_CFG, 32'h2f);
    xfer(1'b1, ADDR_CTL, 32'h50);
    xfer(1'b0, ADDR_CTL, 0);
    chk("lock", 32'h68, q);
    xfer(1'b1, ADDR_CFG, 32'h2c);
    xfer(1'b1, ADDR_CTL, 32'hd0);
    repeat (3) @(posedge ref_clk);
    clk_en <= 1'b0;
    trg    <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("frozen", 1, 32'(pout));
    clk_en <= 1'b1;
    repeat (6) @(posedge ref_clk);
    stat(1'b0);
    chk("cleared", 0, 32'(pout));
    trg <= 1'b0;
    repeat (6) @(posedge ref_clk);
    stat(1'b1);
    xfer(1'b1, ADDR_CTL, 32'h1);
    xfer(1'b0, ADDR_CTL, 0);
    chk("io locked", 0, q);
    xfer(1'b1, ADDR_EN, 0);
    for (int c = 1; c < 5; c++) begin
      xfer(1'b1, ADDR_CTL, {1'b0, c[2], 28'h0, c[1:0]});
      xfer(1'b0, ADDR_CTL, 0);
      chk("io mode", {1'b0, c[2], 28'h0, c[1:0]}, q);
      chk("input", 32'(c % 2), 32'(isel));
    end
    tint <= 1'b0;
    xfer(1'b1, ADDR_CTL, 32'h3);
    repeat (2) @(posedge ref_clk);
    chk("no trigger", 0, 32'(isel));
    xfer(1'b1, ADDR_CTL, 32'h40000001);
    xfer(1'b0, ADDR_CTL, 0);
    chk("reserved mode", 32'h40000001, q);
    chk("reserved input", 0, 32'(isel));
    xfer(1'b1, ADDR_CFG, 32'h20);
    xfer(1'b1, ADDR_EN, 32'h400);
    xfer(1'b1, ADDR_CTL, 0);
    xfer(1'b0, ADDR_CTL, 0);
    chk("single idle", 0, q);
    chk("multi off", 0, 32'(mout));
    xfer(1'b0, 8'h80, 0);
    chk("unmapped", 0, q);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    xfer(1'b0, ADDR_CTL, 0);
    chk("ctl again", 0, q);
    finish_test();
  end
endmodule : tb
`default_nettype wire
